//--- tocq_pkg.sv
/*
 * tocq_pkg: shared constants and types of the timer output compare block.
 * assumes: one 40 MHz system clock, classic wishbone slave with 8-bit data.
 */
package tocq_pkg;

	// ****************************************************************
	// register offsets (byte addresses, one 32-bit word each)
	// ****************************************************************
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_MODE = 8'h04;
	localparam logic [7:0] ADR_CHEN = 8'h08;
	localparam logic [7:0] ADR_CMPL = 8'h0c;
	localparam logic [7:0] ADR_CMPH = 8'h10;
	localparam logic [7:0] ADR_CNTL = 8'h14;
	localparam logic [7:0] ADR_CNTH = 8'h18;
	localparam logic [7:0] ADR_CAP0L = 8'h1c;
	localparam logic [7:0] ADR_CAP0H = 8'h20;
	localparam logic [7:0] ADR_CAP1L = 8'h24;
	localparam logic [7:0] ADR_CAP1H = 8'h28;
	localparam logic [7:0] ADR_STAT = 8'h2c;
	localparam logic [7:0] ADR_MASK = 8'h30;
	localparam logic [7:0] ADR_PORT = 8'h34;
	localparam logic [7:0] ADR_PRE = 8'h38;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CTRL_RUN_BIT = 7;
	localparam int CHEN_OUT_BIT = 6;
	localparam int PORT_OUT_BIT = 4;
	localparam int CHEN_CAP0_BIT = 4;
	localparam int CHEN_CAP1_BIT = 5;
	localparam int ST_OVF = 0;
	localparam int ST_CAP0 = 1;
	localparam int ST_CAP1 = 2;
	localparam int ST_CMP0 = 3;
	localparam int ST_CMP1 = 4;
	localparam int NUM_IRQ = 5;

	// ****************************************************************
	// reset values and the counter maximum
	// ****************************************************************
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_CHEN = 8'h00;
	localparam logic [7:0] RST_PORT = 8'h00;
	localparam logic [7:0] RST_PRE = 8'h00;
	localparam logic [15:0] RST_CMP = 16'hffff;
	localparam logic [15:0] CNT_MAX = 16'hffff;

	// compare action codes held in the compare mode register bits 1:0
	typedef enum logic [1:0] {
		TOCQ_ACT_NONE = 2'b00,
		TOCQ_ACT_HIGH = 2'b01,
		TOCQ_ACT_LOW = 2'b10,
		TOCQ_ACT_TOGGLE = 2'b11
	} tocq_act_t;

	// register write strobe bundle
	typedef struct packed {
		logic wr;
		logic [7:0] adr;
		logic [7:0] dat;
	} tocq_wr_t;

	// one-cycle interrupt request pulses
	typedef struct packed {
		logic cmp1;
		logic cmp0;
		logic cap1;
		logic cap0;
		logic ovf;
	} tocq_irq_t;

endpackage

//--- tocq_capture.sv
/*
 * tocq_capture: one input capture channel with edge detect.
 * assumes: pin already synchronised by the caller; same clock throughout.
 */
module tocq_capture (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic pin_sync,
	input wire logic enable,
	input wire logic [15:0] count,
	output logic [15:0] value,
	output logic irq
);
	import tocq_pkg::*;

	logic pin_d;
	wire edge_seen = enable && (pin_sync != pin_d);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pin_d <= 1'b0;
			value <= 16'h0000;
			irq <= 1'b0;
		end else begin
			pin_d <= pin_sync;
			irq <= edge_seen; // R15
			if (edge_seen) begin
				value <= count; // R15
			end
		end
	end

endmodule // tocq_capture

//--- tocq_compare.sv
/*
 * tocq_compare: a compare channel without pin action, match pulse only.
 * assumes: check marks one timer increment, count already updated.
 */
module tocq_compare (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic check,
	input wire logic [15:0] count,
	input wire logic [15:0] value,
	output logic irq
);
	import tocq_pkg::*;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= check && (count == value); // R16
		end
	end

endmodule // tocq_compare

//--- tocq_timer.sv
/*
 * tocq_timer: 16-bit free running timer with output compare channel zero,
 * two capture channels, a spare compare channel and five irq pulses.
 * assumes: classic wishbone master on clk_sys, capture pins asynchronous,
 * the pin mux outside takes compare_out_pin when chan_sel is high.
 */
// Register access over Wishbone and the placing of the registers were left to the implementer.
// What this block does
// R1: mode field picks high, low, toggle or no change on a match.
// R2: compare value loads only when the upper byte write completes.
// R3: software writes the lower compare byte before the upper byte.
// R4: on timer equal compare value, apply the selected pin action.
// R5: compare interrupt rises after the pin change, never before.
// R6: after a match, ignore matches until the upper byte is written.
// R7: writing zero to the run bit re-arms the compare function.
// R8: no-change mode raises only the interrupt; pin level stays.
// R9: mode field 11 inverts the pin on every match.
// R10: mode register value 01h selects drive-high for channel zero.
// R11: mode register value 03h selects toggle for channel zero.
// R12: software sets the pin's port data latch to one first.
// R13: channel enable value 40h hands the pin to the compare channel.
// R14: overflow raises an interrupt and counting continues upward.
// R15: a capture edge loads the timer value into that channel's capture register and raises its request.
// R16: each compare channel raises its own request on a match.
// R17: five separate request outputs: overflow, two capture, two compare.
// R18: timer counts up on its source tick, overflow at ffffh.
// R19: requests are one-cycle pulses; matches checked once per increment.
module tocq_timer (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	input wire logic capture_pin_zero,
	input wire logic capture_pin_one,
	output logic compare_out_pin,
	output logic chan_sel,
	output logic port_latch,
	output tocq_pkg::tocq_irq_t irq_pulse,
	output logic irq
);
	import tocq_pkg::*;

	// ****************************************************************
	// wishbone slave
	// ****************************************************************
	logic [7:0] ctrl;
	logic [7:0] compare_mode_reg;
	logic [7:0] channel_enable_reg;
	logic [7:0] port_reg;
	logic [7:0] pre_reg;
	logic [7:0] cmp_low;
	logic [15:0] compare_value_reg;
	logic [15:0] cmp1_value;
	logic [15:0] timer_count_reg;
	logic [15:0] cap0_value;
	logic [15:0] cap1_value;
	logic [NUM_IRQ-1:0] status;
	logic [NUM_IRQ-1:0] mask;
	logic [7:0] rd_mux;

	// single-cycle answer: ack one edge after the request is seen
	wire req = cyc_i && stb_i && !ack_o;
	wire wr_lane = we_i && sel_i[0];
	wire wr = req && wr_lane;
	wire rd = req && !we_i;
	wire wr_ctrl = wr && (adr_i == ADR_CTRL);
	wire wr_mode = wr && (adr_i == ADR_MODE);
	wire wr_chen = wr && (adr_i == ADR_CHEN);
	wire wr_cmpl = wr && (adr_i == ADR_CMPL);
	wire wr_cmph = wr && (adr_i == ADR_CMPH);
	wire wr_cntl = wr && (adr_i == ADR_CNTL);
	wire wr_cnth = wr && (adr_i == ADR_CNTH);
	wire wr_mask = wr && (adr_i == ADR_MASK);
	wire wr_port = wr && (adr_i == ADR_PORT);
	wire wr_pre = wr && (adr_i == ADR_PRE);
	wire rd_stat = rd && (adr_i == ADR_STAT);

	always_comb begin
		unique case (adr_i)
			ADR_CTRL: rd_mux = ctrl;
			ADR_MODE: rd_mux = compare_mode_reg;
			ADR_CHEN: rd_mux = channel_enable_reg;
			ADR_CMPL: rd_mux = compare_value_reg[7:0];
			ADR_CMPH: rd_mux = compare_value_reg[15:8];
			ADR_CNTL: rd_mux = timer_count_reg[7:0];
			ADR_CNTH: rd_mux = timer_count_reg[15:8];
			ADR_CAP0L: rd_mux = cap0_value[7:0];
			ADR_CAP0H: rd_mux = cap0_value[15:8];
			ADR_CAP1L: rd_mux = cap1_value[7:0];
			ADR_CAP1H: rd_mux = cap1_value[15:8];
			ADR_STAT: rd_mux = {3'b000, status};
			ADR_MASK: rd_mux = {3'b000, mask};
			ADR_PORT: rd_mux = port_reg;
			ADR_PRE: rd_mux = pre_reg;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req;
			if (rd) begin
				dat_o <= {24'h000000, rd_mux};
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl <= RST_CTRL;
			compare_mode_reg <= RST_MODE;
			channel_enable_reg <= RST_CHEN;
			port_reg <= RST_PORT;
			pre_reg <= RST_PRE;
			cmp_low <= 8'h00;
			mask <= '0;
		end else begin
			if (wr_ctrl) ctrl <= dat_i[7:0];
			if (wr_mode) compare_mode_reg <= dat_i[7:0]; // R10 R11
			if (wr_chen) channel_enable_reg <= dat_i[7:0]; // R13
			if (wr_port) port_reg <= dat_i[7:0];
			if (wr_pre) pre_reg <= dat_i[7:0];
			if (wr_cmpl) cmp_low <= dat_i[7:0]; // R3
			if (wr_mask) mask <= dat_i[NUM_IRQ-1:0];
		end
	end

	// the lower byte waits in cmp_low; only the upper write moves both
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			compare_value_reg <= RST_CMP;
		end else if (wr_cmph) begin
			compare_value_reg <= {dat_i[7:0], cmp_low}; // R2
		end
	end

	// ****************************************************************
	// prescaler and counter
	// ****************************************************************
	logic [7:0] pre_cnt;
	logic tick;
	logic cnt_low_hold;
	wire running = ctrl[CTRL_RUN_BIT];
	wire pre_end = (pre_cnt == pre_reg);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pre_cnt <= 8'h00;
			tick <= 1'b0;
		end else begin
			tick <= running && pre_end;
			if (!running || pre_end) begin
				pre_cnt <= 8'h00;
			end else begin
				pre_cnt <= pre_cnt + 8'h01;
			end
		end
	end

	// counter loads as a 16-bit pair, upper byte write is the trigger
	logic ovf_pulse;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			timer_count_reg <= 16'h0000;
			cnt_low_hold <= 1'b0;
			cmp1_value <= RST_CMP;
			ovf_pulse <= 1'b0;
		end else begin
			ovf_pulse <= 1'b0;
			cnt_low_hold <= 1'b0;
			if (wr_cntl) cmp1_value[7:0] <= dat_i[7:0];
			if (wr_cnth) begin
				timer_count_reg <= {dat_i[7:0], cmp1_value[7:0]};
			end else if (tick) begin
				timer_count_reg <= timer_count_reg + 16'h0001; // R18
				ovf_pulse <= (timer_count_reg == CNT_MAX); // R14
			end
		end
	end

	// ****************************************************************
	// compare channel zero
	// ****************************************************************
	// check one cycle after the increment so the new count is compared
	logic check;
	logic armed;
	logic cmp0_hit;
	logic cmp0_irq;
	logic out_level;
	wire run_clear = wr_ctrl && !dat_i[CTRL_RUN_BIT];
	wire match0 = check && armed && (timer_count_reg == compare_value_reg);
	wire tocq_act_t act = tocq_act_t'(compare_mode_reg[1:0]); // R1
	logic next_out;

	always_comb begin
		unique case (act)
			TOCQ_ACT_HIGH: next_out = 1'b1; // R10
			TOCQ_ACT_LOW: next_out = 1'b0;
			TOCQ_ACT_TOGGLE: next_out = !out_level; // R9 R11
			TOCQ_ACT_NONE: next_out = out_level; // R8
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			check <= 1'b0;
			armed <= 1'b1;
			cmp0_hit <= 1'b0;
			cmp0_irq <= 1'b0;
			out_level <= 1'b0;
		end else begin
			check <= tick; // R19
			cmp0_hit <= match0;
			cmp0_irq <= cmp0_hit; // R5
			if (match0) begin
				out_level <= next_out; // R4
			end
			if (wr_cmph || run_clear) begin
				armed <= 1'b1; // R6 R7
			end else if (match0) begin
				armed <= 1'b0; // R6
			end
		end
	end

	// ****************************************************************
	// spare compare channel and capture channels
	// ****************************************************************
	logic cmp1_irq;
	logic cap0_irq;
	logic cap1_irq;
	logic [1:0] cap_s1;
	logic [1:0] cap_s2;

	// cmp1 reuses the low count staging byte as its compare value
	tocq_compare u_cmp1 (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.check(check),
		.count(timer_count_reg),
		.value({8'h00, cmp1_value[7:0]}),
		.irq(cmp1_irq)
	);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cap_s1 <= 2'b00;
			cap_s2 <= 2'b00;
		end else begin
			cap_s1 <= {capture_pin_one, capture_pin_zero};
			cap_s2 <= cap_s1;
		end
	end

	tocq_capture u_cap0 (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.pin_sync(cap_s2[0]),
		.enable(channel_enable_reg[CHEN_CAP0_BIT]),
		.count(timer_count_reg),
		.value(cap0_value),
		.irq(cap0_irq)
	);

	tocq_capture u_cap1 (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.pin_sync(cap_s2[1]),
		.enable(channel_enable_reg[CHEN_CAP1_BIT]),
		.count(timer_count_reg),
		.value(cap1_value),
		.irq(cap1_irq)
	);

	// ****************************************************************
	// interrupts and pin
	// ****************************************************************
	wire [NUM_IRQ-1:0] ev = {cmp1_irq, cmp0_irq, cap1_irq, cap0_irq,
		ovf_pulse};

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			status <= '0;
		end else if (rd_stat) begin
			status <= ev; // read clears, but a same-cycle event survives
		end else begin
			status <= status | ev;
		end
	end

	assign irq_pulse = tocq_irq_t'(ev); // R17 R19
	assign irq = |(status & mask);
	assign chan_sel = channel_enable_reg[CHEN_OUT_BIT]; // R13
	assign port_latch = port_reg[PORT_OUT_BIT]; // R12
	assign compare_out_pin = out_level;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	AST_IRQ_AFTER_PIN: assert property ( // R5
		match0 |=> ##1 cmp0_irq)
		else $error("compare irq not two cycles after match");
	AST_HIGH: assert property ( // R10
		match0 && act == TOCQ_ACT_HIGH |=> out_level)
		else $error("drive-high action failed");
	AST_LOW: assert property ( // R1
		match0 && act == TOCQ_ACT_LOW |=> !out_level)
		else $error("drive-low action failed");
	AST_TOGGLE: assert property ( // R9
		match0 && act == TOCQ_ACT_TOGGLE |=> out_level != $past(out_level))
		else $error("toggle action failed");
	AST_NOCHANGE: assert property ( // R8
		match0 && act == TOCQ_ACT_NONE |=> $stable(out_level))
		else $error("no-change mode moved pin");
	AST_DISARM: assert property ( // R6
		match0 && !wr_cmph && !run_clear |=> !armed)
		else $error("compare not disarmed after match");
	AST_REARM: assert property ( // R7
		run_clear |=> armed)
		else $error("run clear did not re-arm");
	AST_LOW_ONLY: assert property ( // R2
		wr_cmpl && !wr_cmph |=> $stable(compare_value_reg))
		else $error("low byte write changed compare value");
	AST_OVF: assert property ( // R14
		tick && !wr_cnth && timer_count_reg == CNT_MAX
		|=> ovf_pulse && timer_count_reg == 16'h0000)
		else $error("overflow not flagged or count stopped");
	AST_PULSE: assert property ( // R19
		cmp0_irq |=> !cmp0_irq)
		else $error("compare irq longer than one cycle");
	AST_IRQ_OUT: assert property ( // R17
		ev != '0 |=> (status & $past(ev)) == $past(ev))
		else $error("event did not set its status bit");

	COV_MATCH: cover property (match0);
	COV_TOGGLE: cover property (match0 && act == TOCQ_ACT_TOGGLE);
	COV_OVF: cover property (ovf_pulse);
	COV_CAP: cover property (cap0_irq);

endmodule // tocq_timer

//--- tocq_timer_tb_top.sv
/*
 * tocq_timer_tb_top: self-checking bench of the timer output compare block.
 * assumes: tocq_pkg compiled first; the assertions live in the design files.
 */
module tocq_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import tocq_pkg::*;

	// ****************************************************************
	// signals and bookkeeping
	// ****************************************************************
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic we_i = 1'b0;
	logic [3:0] sel_i = 4'h0;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic ack_o;
	logic cap_zero = 1'b0;
	logic cap_one = 1'b0;
	logic compare_out_pin;
	logic chan_sel;
	logic port_latch;
	logic irq;
	tocq_irq_t irq_pulse;
	logic [4:0] ipv;
	int bad_count = 0;
	int cmp_count = 0;
	logic [63:0] rd_q[$];
	logic [5:0] ev_q[$];
	logic [63:0] ent;
	logic [31:0] seed = 32'h31;
	logic [31:0] cv = 32'h0;
	logic pin = 1'b0;
	logic [7:0] modes [7] = '{8'h01, 8'h03, 8'h03, 8'h02, 8'h00, 8'h01, 8'h00};

	assign ipv = irq_pulse;

	tocq_timer uut (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.adr_i(adr_i),
		.dat_i(dat_i),
		.dat_o(dat_o),
		.we_i(we_i),
		.sel_i(sel_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.ack_o(ack_o),
		.capture_pin_zero(cap_zero),
		.capture_pin_one(cap_one),
		.compare_out_pin(compare_out_pin),
		.chan_sel(chan_sel),
		.port_latch(port_latch),
		.irq_pulse(irq_pulse),
		.irq(irq)
	);

	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ****************************************************************
	// compare, report and bus tasks
	// ****************************************************************
	task automatic tally(string nm, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cmp_rd(logic [31:0] e, logic [31:0] g);
		tally("read data", e, g);
	endtask

	task automatic cmp_evt(logic [5:0] e, logic [5:0] g);
		tally("irq pulses and pin", {26'h0, e}, {26'h0, g});
	endtask

	task automatic cmp_lvl(string nm, logic e, logic g);
		tally(nm, {31'h0, e}, {31'h0, g});
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// classic cycle: hold everything until ack is sampled, then release
	task automatic bus(logic w, logic [7:0] a, logic [7:0] d,
		logic [31:0] e, logic [31:0] m);
		int n;
		@(posedge clk_sys);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		sel_i <= 4'h1;
		if (!w)
			rd_q.push_back({m, e & m});
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		if (n >= 50) begin
			bad_count++;
			$display("BAD ack expected 1 seen %b", ack_o);
			summarize();
		end
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		bus(1'b1, a, d, 32'h0, 32'h0);
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
		bus(1'b0, a, 8'h00, e, m);
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// ****************************************************************
	// result watchers: oldest note against what appears
	// ****************************************************************
	always @(posedge clk_sys) begin
		if (ack_o === 1'b1 && we_i === 1'b0) begin
			ent = (rd_q.size() > 0) ? rd_q.pop_front() : 64'h0;
			cmp_rd(ent[31:0], dat_o & ent[63:32]);
		end
		if ((|ipv) !== 1'b0) begin
			if (ev_q.size() == 0)
				cmp_evt(6'h00, {ipv, compare_out_pin});
			else
				cmp_evt(ev_q.pop_front(), {ipv, compare_out_pin});
		end
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		$display("BAD watchdog expected done seen running");
		summarize();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		rd(8'h3c, 32'h0, 32'hffffffff);
		rd(ADR_MODE, {24'h0, RST_MODE}, 32'hff);
		wr(ADR_PORT, 8'h10);
		wr(ADR_CHEN, 8'h40);
		@(posedge clk_sys);
		cmp_lvl("port_latch", 1'b1, port_latch);
		cmp_lvl("chan_sel", 1'b1, chan_sel);
		// low byte alone: the pass over 0030 must stay silent
		wr(ADR_CMPL, 8'h30);
		wr(ADR_MODE, 8'h01);
		wr(ADR_CNTL, 8'h00);
		wr(ADR_CNTH, 8'h00);
		wr(ADR_CTRL, 8'h80);
		repeat (128) @(posedge clk_sys);
		foreach (modes[i]) begin
			wr(ADR_CTRL, 8'h00);
			wr(ADR_MODE, modes[i]);
			// pass 2 keeps the old value: only the stop re-arms it
			if (i != 2) begin
				seed = xs(seed);
				cv = 32'h10 + (seed & 32'h3f);
				wr(ADR_CMPL, cv[7:0]);
				wr(ADR_CMPH, cv[15:8]);
			end
			wr(ADR_CNTL, 8'h00);
			wr(ADR_CNTH, 8'h00);
			case (modes[i][1:0])
				2'b01: pin = 1'b1;
				2'b10: pin = 1'b0;
				2'b11: pin = ~pin;
				default: pin = pin;
			endcase
			ev_q.push_back({5'h08, pin});
			wr(ADR_CTRL, 8'h80);
			repeat (128) @(posedge clk_sys);
			// rewind while running: channel zero stays quiet, the spare
			// channel hits count 0000 against its 00 staging byte
			ev_q.push_back({5'h10, pin});
			wr(ADR_CNTL, 8'h00);
			wr(ADR_CNTH, 8'h00);
			repeat (128) @(posedge clk_sys);
		end
		wr(ADR_CTRL, 8'h00);
		wr(ADR_MASK, 8'h01);
		rd(ADR_STAT, 32'h18, 32'h1f);
		wr(ADR_CNTL, 8'hf0);
		wr(ADR_CNTH, 8'hff);
		ev_q.push_back({5'h01, pin});
		wr(ADR_CTRL, 8'h80);
		// short run so the count wraps past ffff and stops below any compare value
		repeat (24) @(posedge clk_sys);
		wr(ADR_CTRL, 8'h00);
		cmp_lvl("irq", 1'b1, irq);
		rd(ADR_CNTH, 32'h0, 32'hff);
		rd(ADR_STAT, 32'h01, 32'h1f);
		@(posedge clk_sys);
		cmp_lvl("irq", 1'b0, irq);
		wr(ADR_CHEN, 8'h70);
		ev_q.push_back({5'h02, pin});
		cap_zero <= 1'b1;
		repeat (10) @(posedge clk_sys);
		ev_q.push_back({5'h04, pin});
		cap_one <= 1'b1;
		repeat (10) @(posedge clk_sys);
		cmp_lvl("irq", 1'b0, irq);
		wr(ADR_MASK, 8'h02);
		@(posedge clk_sys);
		cmp_lvl("irq", 1'b1, irq);
		rd(ADR_CAP0H, 32'h0, 32'hff);
		rd(ADR_STAT, 32'h06, 32'h1f);
		repeat (4) @(posedge clk_sys);
		cmp_lvl("events left", 1'b1, ev_q.size() == 0);
		summarize();
	end

endmodule // tocq_timer_tb_top
